/* shared/hlwd_cfg.svh */
`ifndef HLWD_CFG_SVH
`define HLWD_CFG_SVH

// Register offsets on the plain register port
`define HLWD_OFF_CTRL     8'h00
`define HLWD_OFF_SAFE     8'h04
`define HLWD_OFF_STATUS   8'h08
`define HLWD_OFF_ACTIVE   8'h0C
`define HLWD_OFF_PENDING  8'h10

// Control register fields
`define HLWD_CTRL_EN_BIT      0
`define HLWD_CTRL_ALARM_BIT   1
`define HLWD_CTRL_TMO_LSB     8
`define HLWD_CTRL_TMO_MSB     15

// Status register fields
`define HLWD_STAT_TMO_BIT     0
`define HLWD_STAT_INIT_BIT    1
`define HLWD_STAT_RUN_BIT     2

// Communication word fields (active and pending registers)
`define HLWD_COMM_CKSUM_BIT   0
`define HLWD_COMM_PAR_LSB     1
`define HLWD_COMM_PAR_MSB     2
`define HLWD_COMM_BAUD_LSB    3
`define HLWD_COMM_BAUD_MSB    6
`define HLWD_COMM_ADDR_LSB    7
`define HLWD_COMM_ADDR_MSB    14
`define HLWD_COMM_PROTO_BIT   15

// Reset values
`define HLWD_RST_TMO          8'h0A
`define HLWD_RST_SAFE         32'h0000_0000

// Forced defaults with the configuration-default switch on
`define HLWD_DEF_PROTO        1'b0
`define HLWD_DEF_ADDR         8'h00
`define HLWD_DEF_BAUD         4'h6
`define HLWD_DEF_PARITY       2'h0
`define HLWD_DEF_CKSUM        1'b0

// Timing: timeout unit is 0.1 s, clock in kHz
`define HLWD_TICK_MS          100
`define HLWD_CLK_KHZ          125000
`define HLWD_BOOT_CYCLES      2'h3

`endif

/* shared/hlwd_pkg.sv */
package hlwd_pkg;

  // Number of output channels guarded by the watchdog
  localparam int HLWD_CH = 32;

  // Protocol selector
  typedef enum logic
  {
    HLWD_PROTO_ASCII  = 1'b0,
    HLWD_PROTO_MODBUS = 1'b1
  } hlwd_proto_e;

  // Communication settings word
  typedef struct packed
  {
    hlwd_proto_e proto;
    logic [7:0]  addr;
    logic [3:0]  baud;
    logic [1:0]  parity;
    logic        cksum;
  } hlwd_comm_s;

  // Boot sequencing states, one-hot
  typedef enum logic [1:0]
  {
    HLWD_ST_BOOT = 2'b01,
    HLWD_ST_RUN  = 2'b10
  } hlwd_state_e;

  // Register port request
  typedef struct packed
  {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } hlwd_bus_s;

  // Command strobes from the serial command decoder
  typedef struct packed
  {
    logic               keepalive;
    logic               clear;
    logic               out_wr;
    logic [HLWD_CH-1:0] out_data;
  } hlwd_cmd_s;

  // Tick divider state
  typedef struct packed
  {
    logic [23:0] cnt;
    logic        tick;
  } hlwd_tick_s;

  // Whole state of the watchdog block
  typedef struct packed
  {
    hlwd_state_e        state;
    logic [1:0]         boot_cnt;
    logic               sw_meta;
    logic               sw_sync;
    logic               init_mode;
    logic               wdt_en;
    logic               alarm_en;
    logic [7:0]         tmo_units;
    logic [7:0]         ticks;
    logic               tmo_flag;
    logic [HLWD_CH-1:0] host_val;
    logic [HLWD_CH-1:0] safe_val;
    logic [HLWD_CH-1:0] out_val;
    hlwd_comm_s         active;
    hlwd_comm_s         pending;
    logic               nv_stb;
    logic [31:0]        rdata;
  } hlwd_state_s;

endpackage

/* logic/hlwd_tick.sv */
`timescale 1ns/1ns
`include "hlwd_cfg.svh"

// Divider that emits a one-cycle enable every CYCLES clocks
module hlwd_tick
#(
  parameter int CYCLES = 12500000
)
(
  input  wire logic sys_clk,   // System clock
  input  wire logic rst_n,     // Synchronous reset, active low
  input  wire logic run,       // Count while high
  input  wire logic restart,   // Start a fresh period
  output logic      tick       // One-cycle enable
);
  import hlwd_pkg::*;

  localparam logic [23:0] LAST = 24'(CYCLES - 1);

  hlwd_tick_s st_reg;          // Registered state
  hlwd_tick_s st_next;         // Next state

  ////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    // Restart realigns the period so the timeout is measured from the event
    if (restart || !run)
    begin
      st_next.cnt = 24'h00_0000;
    end
    else if (st_reg.cnt >= LAST)
    begin
      st_next.cnt  = 24'h00_0000;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 24'h00_0001;
    end
  end

  ////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

endmodule

/* logic/hlwd_top.sv */
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "hlwd_cfg.svh"

module hlwd_top
#(
  parameter int TICK_CYCLES = `HLWD_TICK_MS * `HLWD_CLK_KHZ  // Clocks per 0.1 s
)
(
  input  wire logic                      sys_clk,       // System clock, 125 MHz
  input  wire logic                      rst_n,         // Synchronous reset, active low (power-up)
  input  wire hlwd_pkg::hlwd_bus_s       bus,           // Register port request
  output logic [31:0]                    bus_rdata,     // Read data, cycle after read strobe
  input  wire hlwd_pkg::hlwd_cmd_s       cmd,           // Decoded host commands
  output logic                           cmd_refused,   // Output write refused while timed out
  input  wire logic                      alarm_active,  // Alarm condition, same clock
  input  wire logic                      dip_switch_bank, // Configuration-default switch pin
  input  wire hlwd_pkg::hlwd_comm_s      nv_rd_data,    // Stored settings from non-volatile store
  output hlwd_pkg::hlwd_comm_s           nv_wr_data,    // Settings to save
  output logic                           nv_wr_stb,     // Save strobe
  output hlwd_pkg::hlwd_comm_s           comm_active,   // Settings in use
  output logic [hlwd_pkg::HLWD_CH-1:0]   out_value,     // Guarded output channels
  output logic                           wdt_timeout    // Latched timeout status
);
  import hlwd_pkg::*;

  localparam logic [HLWD_CH-1:0] ALL_ON = {HLWD_CH{1'b1}};

  hlwd_state_s st_reg;         // Registered state
  hlwd_state_s st_next;        // Next state
  logic        tick;           // 0.1 s enable
  logic        tick_run;       // Divider runs only while counting matters

  ////////////////////////////////////////////////////////////////
  // Helpers

  // A zero timeout would fire at once; treat it as the shortest step
  function automatic logic [7:0] eff_tmo(input logic [7:0] units);
    eff_tmo = (units == 8'h00) ? 8'h01 : units;
  endfunction

  // Unpack a bus word into a settings word
  function automatic hlwd_comm_s word_to_comm(input logic [31:0] w);
    hlwd_comm_s c;
    c.proto  = hlwd_proto_e'(w[`HLWD_COMM_PROTO_BIT]);
    c.addr   = w[`HLWD_COMM_ADDR_MSB:`HLWD_COMM_ADDR_LSB];
    c.baud   = w[`HLWD_COMM_BAUD_MSB:`HLWD_COMM_BAUD_LSB];
    c.parity = w[`HLWD_COMM_PAR_MSB:`HLWD_COMM_PAR_LSB];
    c.cksum  = w[`HLWD_COMM_CKSUM_BIT];
    return c;
  endfunction

  // Pack a settings word into the low half of a bus word
  function automatic logic [31:0] comm_to_word(input hlwd_comm_s c);
    comm_to_word = {16'h0000, c};
  endfunction

  ////////////////////////////////////////////////////////////////
  // 0.1 s time base
  assign tick_run = st_reg.wdt_en && !st_reg.tmo_flag && (st_reg.state == HLWD_ST_RUN);

  hlwd_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (tick_run),
    .restart (cmd.keepalive),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    hlwd_comm_s req;           // Requested settings from a write
    logic       tmo_set;       // Timeout event this cycle
    req          = word_to_comm(bus.wdata);
    tmo_set      = 1'b0;
    st_next      = st_reg;
    st_next.nv_stb = 1'b0;
    st_next.rdata  = 32'h0000_0000;

    // Switch pin synchroniser; only the second stage is read
    st_next.sw_meta = dip_switch_bank;
    st_next.sw_sync = st_reg.sw_meta;

    // Boot: let the switch settle through the synchroniser, then latch mode
    unique case (st_reg.state)
      HLWD_ST_BOOT:
      begin
        st_next.boot_cnt = st_reg.boot_cnt + 2'h1;
        if (st_reg.boot_cnt == `HLWD_BOOT_CYCLES)
        begin
          st_next.state     = HLWD_ST_RUN;
          st_next.init_mode = st_reg.sw_sync;
          st_next.pending   = nv_rd_data;
          if (st_reg.sw_sync)
          begin
            // Forced defaults
            st_next.active.proto  = hlwd_proto_e'(`HLWD_DEF_PROTO);
            st_next.active.addr   = `HLWD_DEF_ADDR;
            st_next.active.baud   = `HLWD_DEF_BAUD;
            st_next.active.parity = `HLWD_DEF_PARITY;
            st_next.active.cksum  = `HLWD_DEF_CKSUM;
          end
          else
          begin
            // Stored settings take effect only here, at power-up
            st_next.active = nv_rd_data;
          end
        end
      end
      HLWD_ST_RUN:
      begin
        st_next.boot_cnt = st_reg.boot_cnt;
      end
    endcase

    // Register writes
    if (bus.wr)
    begin
      unique case (bus.addr)
        `HLWD_OFF_CTRL:
        begin
          st_next.wdt_en    = bus.wdata[`HLWD_CTRL_EN_BIT];
          st_next.alarm_en  = bus.wdata[`HLWD_CTRL_ALARM_BIT];
          st_next.tmo_units = bus.wdata[`HLWD_CTRL_TMO_MSB:`HLWD_CTRL_TMO_LSB];
        end
        `HLWD_OFF_SAFE:
        begin
          st_next.safe_val = bus.wdata[HLWD_CH-1:0];
        end
        `HLWD_OFF_PENDING:
        begin
          if (st_reg.state == HLWD_ST_RUN)
          begin
            // Address is always writable
            st_next.pending.addr = req.addr;
            if (st_reg.init_mode)
            begin
              // Switch mode: every field may change
              st_next.pending = req;
            end
            else if (st_reg.active.proto == HLWD_PROTO_MODBUS)
            begin
              st_next.pending.baud   = req.baud;
              st_next.pending.parity = req.parity;
            end
            // Saved for next power-up; active settings stay as they are
            st_next.nv_stb = 1'b1;
          end
        end
        default:
        begin
          // Unmapped or read-only: write ignored
        end
      endcase
    end

    // Register reads, answered in the next cycle
    if (bus.rd)
    begin
      unique case (bus.addr)
        `HLWD_OFF_CTRL:
        begin
          st_next.rdata[`HLWD_CTRL_EN_BIT]                     = st_reg.wdt_en;
          st_next.rdata[`HLWD_CTRL_ALARM_BIT]                  = st_reg.alarm_en;
          st_next.rdata[`HLWD_CTRL_TMO_MSB:`HLWD_CTRL_TMO_LSB] = st_reg.tmo_units;
        end
        `HLWD_OFF_SAFE:
        begin
          st_next.rdata = st_reg.safe_val;
        end
        `HLWD_OFF_STATUS:
        begin
          st_next.rdata[`HLWD_STAT_TMO_BIT]  = st_reg.tmo_flag;
          st_next.rdata[`HLWD_STAT_INIT_BIT] = st_reg.init_mode;
          st_next.rdata[`HLWD_STAT_RUN_BIT]  = (st_reg.state == HLWD_ST_RUN);
        end
        `HLWD_OFF_ACTIVE:
        begin
          st_next.rdata = comm_to_word(st_reg.active);
        end
        `HLWD_OFF_PENDING:
        begin
          st_next.rdata = comm_to_word(st_reg.pending);
        end
        default:
        begin
          st_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Watchdog counting; the host keeps it alive by repeating keep-alive
    if (!st_next.wdt_en)
    begin
      // Disabled: no count, no timeout, nothing latched
      st_next.ticks    = 8'h00;
      st_next.tmo_flag = 1'b0;
    end
    else
    begin
      if (st_reg.tmo_flag)
      begin
        st_next.ticks = 8'h00;
      end
      else if (cmd.keepalive)
      begin
        st_next.ticks = 8'h00;
      end
      else if (tick)
      begin
        st_next.ticks = st_reg.ticks + 8'h01;
        tmo_set       = (st_reg.ticks + 8'h01) >= eff_tmo(st_reg.tmo_units);
      end
      // While enabled, only the clear command releases the latch; a new timeout wins
      if (tmo_set)
      begin
        st_next.tmo_flag = 1'b1;
      end
      else if (cmd.clear)
      begin
        st_next.tmo_flag = 1'b0;
      end
    end

    // Host output writes are dropped while timed out
    if (cmd.out_wr && !st_reg.tmo_flag)
    begin
      st_next.host_val = cmd.out_data;
    end

    // Output selection
    if (st_reg.alarm_en)
    begin
      st_next.out_val = alarm_active ? ALL_ON : st_next.host_val;
    end
    else if (st_next.tmo_flag)
    begin
      st_next.out_val = st_reg.safe_val;
    end
    else
    begin
      st_next.out_val = st_next.host_val;
    end
  end

  ////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_reg           <= '0;
      st_reg.state     <= HLWD_ST_BOOT;
      st_reg.tmo_units <= `HLWD_RST_TMO;
      st_reg.safe_val  <= `HLWD_RST_SAFE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs
  assign bus_rdata   = st_reg.rdata;
  assign cmd_refused = cmd.out_wr && st_reg.tmo_flag;
  assign nv_wr_data  = st_reg.pending;
  assign nv_wr_stb   = st_reg.nv_stb;
  assign comm_active = st_reg.active;
  assign out_value   = st_reg.out_val;
  assign wdt_timeout = st_reg.tmo_flag;

endmodule

/* tb/hlwd_asserts.sv */
`timescale 1ns/1ns
// Port-level checks of the timeout flag and guarded outputs
module hlwd_asserts
#(
  parameter int TICK_CYCLES = 10
)
(
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  input wire hlwd_pkg::hlwd_bus_s  bus,
  input wire hlwd_pkg::hlwd_cmd_s  cmd,
  input wire logic                 cmd_refused,
  input wire logic                 alarm_active,
  input wire logic [31:0]          out_value,
  input wire logic                 wdt_timeout
);
  import hlwd_pkg::*;
  logic [31:0] ctrl_reg;  // Shadow of the control register
  logic [31:0] safe_reg;  // Shadow of the safe value
  logic [15:0] gap_reg;   // Cycles since last keep-alive, saturating
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////
  // Shadows follow bus writes on the same edge as the design
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= 32'h0000_0A00;
      safe_reg <= 32'h0;
      gap_reg  <= 16'h0;
    end
    else
    begin
      if (bus.wr && bus.addr == 8'h00)
        ctrl_reg <= bus.wdata;
      if (bus.wr && bus.addr == 8'h04)
        safe_reg <= bus.wdata;
      // Saturate so a long silence never wraps to a small gap
      if (cmd.keepalive)
        gap_reg <= 16'h0;
      else if (gap_reg != 16'hFFFF)
        gap_reg <= gap_reg + 16'h1;
    end
  end
  //////////////////////////////////////////////////////////////////
  property p_refuse;
    cmd.out_wr && wdt_timeout |-> cmd_refused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("output write not refused");
  property p_refuse_only;
    cmd_refused |-> cmd.out_wr && wdt_timeout;
  endproperty
  a_refuse_only: assert property (p_refuse_only) else $error("spurious refusal");
  property p_latched;
    wdt_timeout && ctrl_reg[0] && !cmd.clear && !bus.wr |=> wdt_timeout;
  endproperty
  a_latched: assert property (p_latched) else $error("timeout dropped without clear");
  property p_clear;
    wdt_timeout && cmd.clear && !bus.wr |=> !wdt_timeout;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not release timeout");
  property p_gap;
    $rose(wdt_timeout) |-> gap_reg >= TICK_CYCLES - 1;
  endproperty
  a_gap: assert property (p_gap) else $error("timeout too soon after keep-alive");
  // Out value lags the safe register by one cycle
  property p_safe;
    wdt_timeout && !ctrl_reg[1] && !$past(ctrl_reg[1]) |-> out_value == $past(safe_reg);
  endproperty
  a_safe: assert property (p_safe) else $error("outputs not at safe value");
  property p_alarm;
    ctrl_reg[1] && alarm_active && !bus.wr |=> out_value == 32'hFFFF_FFFF;
  endproperty
  a_alarm: assert property (p_alarm) else $error("outputs not following alarm");
  property p_off;
    !ctrl_reg[0] && !$past(ctrl_reg[0]) |-> !wdt_timeout;
  endproperty
  a_off: assert property (p_off) else $error("timeout while disabled");
  c_tmo: cover property ($rose(wdt_timeout));
  c_refused: cover property (cmd_refused);
  c_alarm: cover property (ctrl_reg[1] && alarm_active && wdt_timeout);
endmodule

bind hlwd_top hlwd_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_asserts
(
  .sys_clk, .rst_n, .bus, .cmd, .cmd_refused, .alarm_active, .out_value, .wdt_timeout
);

/* tb/hlwd_host.sv */
`timescale 1ns/1ns
// Host on the serial link, sending decoded commands
module hlwd_host
(
  input  wire logic          sys_clk,
  output hlwd_pkg::hlwd_cmd_s cmd
);
  import hlwd_pkg::*;
  initial cmd = '0;
  // One command per call; data lines show a changed value afterwards
  task automatic send(input logic [2:0] sel, input logic [31:0] d);
    @(posedge sys_clk);
    cmd <= {sel, d};
    @(posedge sys_clk);
    cmd <= {3'b000, ~d};
  endtask
  // Keep-alive train with gaps kept below the timeout
  task automatic train(input int n, input int gap);
    repeat (n)
    begin
      repeat (gap) @(posedge sys_clk);
      send(3'b100, 32'h0);
    end
  endtask
endmodule

/* tb/tb_host_link_watchdog_init_cfg.sv */
`timescale 1ns/1ns
`include "hlwd_cfg.svh"
module tb_host_link_watchdog_init_cfg;
  import hlwd_pkg::*;
  localparam int TK = 10;  // Short tick for simulation
  localparam logic [15:0] DEF = {`HLWD_DEF_PROTO, `HLWD_DEF_ADDR, `HLWD_DEF_BAUD, `HLWD_DEF_PARITY, `HLWD_DEF_CKSUM};
  logic        sys_clk = 0;
  logic        rst_n = 0;
  logic        alarm_active = 0;
  logic        dip_switch_bank = 1;
  hlwd_bus_s   bus = '0;
  hlwd_cmd_s   cmd;
  hlwd_comm_s  nv_rd_data = '0;
  hlwd_comm_s  nv_wr_data;
  hlwd_comm_s  comm_active;
  logic [31:0] bus_rdata;
  logic [31:0] out_value;
  logic        cmd_refused;
  logic        nv_wr_stb;
  logic        wdt_timeout;
  int          n_errors = 0;
  int          checked = 0;
  int          n_ref = 0;  // Refused output writes seen
  int          n_stb = 0;  // Save strobes seen
  int          seed = 32'he53a;
  int          al;       // Model: alarm enabled
  int          tmo;      // Model: timeout latched
  logic [31:0] safe_m;   // Model: safe value
  logic [31:0] host_m;   // Model: host value
  logic [31:0] got;
  logic [15:0] nv;
  always #4 sys_clk = ~sys_clk;
  // Sample the refusal and the save strobe mid-cycle, where both have settled
  always @(negedge sys_clk)
  begin
    if (cmd_refused === 1'b1)
      n_ref++;
    if (nv_wr_stb === 1'b1)
      n_stb++;
  end
  hlwd_host u_host (.sys_clk, .cmd);
  hlwd_top #(.TICK_CYCLES(TK)) u_dut
  (
    .sys_clk, .rst_n, .bus, .bus_rdata, .cmd, .cmd_refused, .alarm_active, .dip_switch_bank,
    .nv_rd_data, .nv_wr_data, .nv_wr_stb, .comm_active, .out_value, .wdt_timeout
  );
  //////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic conclude;
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Alarm wins over the safe value when enabled
  function automatic logic [31:0] exp_out();
    if (al != 0)
      return alarm_active ? 32'hFFFF_FFFF : host_m;
    return (tmo != 0) ? safe_m : host_m;
  endfunction
  task automatic cko;
    #1 chk(out_value, exp_out());
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 got = bus_rdata;
  endtask
  // Power-up with a given switch position and stored settings
  task automatic boot(input logic sw, input logic [15:0] s);
    @(posedge sys_clk);
    dip_switch_bank <= sw;
    nv_rd_data <= s;
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    al = 0;
    tmo = 0;
    safe_m = 0;
    host_m = 0;
  endtask
  // Bounded wait for the flag after the last keep-alive
  task automatic wait_tmo(input int n);
    int c;
    c = 0;
    while (wdt_timeout !== 1'b1 && c < n * TK + 20)
    begin
      @(posedge sys_clk);
      #1 c++;
    end
    chk(c >= n * TK - 1 && c <= n * TK + 5, 1);
    if (c >= n * TK + 20)
      conclude();
    tmo = 1;
  endtask
  //////////////////////////////////////////////////////////////////
  initial
  begin
    boot(1'b1, 16'h0);
    chk(comm_active, DEF);
    rd(8'h08);
    chk(got, 32'h6);
    rd(8'h0C);
    chk(got, {16'h0, DEF});
    safe_m = $random(seed);
    wr(8'h04, safe_m);
    host_m = $random(seed);
    u_host.send(3'b001, host_m);
    cko();
    u_host.send(3'b100, 32'h0);
    wr(8'h00, 32'h0000_0201);
    u_host.train(10, 15);
    #1 chk(wdt_timeout, 0);
    wait_tmo(2);
    cko();
    u_host.send(3'b001, $random(seed));
    cko();
    chk(n_ref, 1);
    u_host.send(3'b100, 32'h0);
    #1 chk(wdt_timeout, 1);
    u_host.send(3'b010, 32'h0);
    tmo = 0;
    cko();
    chk(wdt_timeout, 0);
    // Alarm mode: flag still latches but outputs track the alarm
    wr(8'h00, 32'h0000_0103);
    al = 1;
    u_host.send(3'b100, 32'h0);
    wait_tmo(1);
    repeat (4)
    begin
      @(posedge sys_clk);
      alarm_active <= 1'($random(seed));
      @(posedge sys_clk);
      cko();
    end
    wr(8'h00, 32'h0000_0100);
    al = 0;
    tmo = 0;
    repeat (60) @(posedge sys_clk);
    chk(wdt_timeout, 0);
    cko();
    rd(8'h00);
    chk(got, 32'h0000_0100);
    // A zero timeout acts as the shortest step
    wr(8'h00, 32'h0000_0001);
    u_host.send(3'b100, 32'h0);
    wait_tmo(1);
    cko();
    // Switch mode takes every field but applies none now
    nv = 16'($random(seed));
    wr(8'h10, {16'h0, nv});
    rd(8'h10);
    chk(got, {16'h0, nv});
    chk(n_stb, 1);
    chk(nv_wr_data, nv);
    chk(comm_active, DEF);
    rd(8'h20);
    chk(got, 32'h0);
    nv = nv | 16'h8000;
    boot(1'b0, nv);
    chk(comm_active, nv);
    rd(8'h08);
    chk(got, 32'h4);
    got = $random(seed);
    wr(8'h10, got);
    #1 chk(nv_wr_data, {nv[15], got[14:1], nv[0]});
    chk(comm_active, nv);
    nv = nv & 16'h7FFF;
    boot(1'b0, nv);
    got = $random(seed);
    wr(8'h10, got);
    #1 chk(nv_wr_data, {nv[15], got[14:7], nv[6:0]});
    @(negedge sys_clk);
    #1 chk(n_stb, 3);
    conclude();
  end
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    chk(0, 1);
    conclude();
  end
endmodule
